// *** rtl/srs_map.vh ***
// Purpose: Constants for the two-wire register access slave
// Assumes: 125 MHz core clock
// Notes: Times are kept as printed; cycle counts derive from them
`ifndef SRS_MAP_VH
`define SRS_MAP_VH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define SRS_CLK_KHZ 125000
`define SRS_T_LOW_MS 30
`define SRS_T_IDLE_US 150
`define SRS_T_QUIET_MS 15
`define SRS_LOW_CYC (`SRS_T_LOW_MS * `SRS_CLK_KHZ)
`define SRS_IDLE_CYC ((`SRS_T_IDLE_US * `SRS_CLK_KHZ) / 1000)
`define SRS_QUIET_CYC (`SRS_T_QUIET_MS * `SRS_CLK_KHZ)
`define SRS_CNT_W 22

// ---------------------------------------------------------------
// Strap codes (resistor level from the strap comparator)
// ---------------------------------------------------------------
`define SRS_STRAP_R47K 3'h0
`define SRS_STRAP_R56K 3'h1
`define SRS_STRAP_R68K 3'h2
`define SRS_STRAP_R82K 3'h3
`define SRS_STRAP_R100K 3'h4
`define SRS_STRAP_R120K 3'h5
`define SRS_STRAP_R150K 3'h6
`define SRS_STRAP_VDD 3'h7

// ---------------------------------------------------------------
// Interface modes and addresses
// ---------------------------------------------------------------
`define SRS_MODE_SPI4 2'h0
`define SRS_MODE_SPI3 2'h1
`define SRS_MODE_LINK 2'h2
`define SRS_MODE_SMB 2'h3
`define SRS_ADDR_R82K 7'h2C
`define SRS_ADDR_R100K 7'h2B
`define SRS_ADDR_R120K 7'h2A
`define SRS_ADDR_R150K 7'h29
`define SRS_ADDR_VDD 7'h28
`define SRS_ADDR_ARA 7'h0C
`define SRS_PTR_RST 8'h00

`endif

// *** rtl/srs_sync.v ***
// Purpose: Two-stage synchroniser for pins from outside the clock domain
// Assumes: Inputs are slow compared with CLK
// Notes: First stage is read only by the second stage
module srs_sync #(
  parameter W = 2
) (
  input wire clk, // Core clock
  input wire rst_n, // Async reset, active low
  input wire [W-1:0] d_in, // Asynchronous inputs
  output wire [W-1:0] q_out // Synchronised outputs
);
  genvar gi;

  // ---------------------------------------------------------------
  // One two-flop chain per bit
  // ---------------------------------------------------------------
  generate
    for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
      reg meta_ff;
      reg sync_ff;
      // Reset to the idle-high level so no false edge follows reset
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff <= 1'b1;
          sync_ff <= 1'b1;
        end else begin
          meta_ff <= d_in[gi];
          sync_ff <= meta_ff;
        end
      end
      assign q_out[gi] = sync_ff;
    end
  endgenerate

endmodule // srs_sync

// *** rtl/srs_strap.v ***
// Purpose: Strap capture, interface decode, slave address and quiet time
// Assumes: Strap level is static once power is good
// Notes: Strap is sampled once after reset release
`include "srs_map.vh"

module srs_strap #(
  parameter [`SRS_CNT_W-1:0] QUIET_CYC = `SRS_QUIET_CYC
) (
  input wire clk, // Core clock
  input wire rst_n, // Async reset, active low
  input wire [2:0] strap_lvl, // Strap comparator code, asynchronous
  output reg [1:0] if_mode, // Selected host interface
  output reg [6:0] slave_addr, // Strap slave address
  output reg ready // Quiet time over
);
  wire [2:0] strap_sync;
  reg [1:0] settle_ff;
  reg [`SRS_CNT_W-1:0] quiet_ff;

  srs_sync #(.W(3)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d_in(strap_lvl),
    .q_out(strap_sync)
  );

  // ---------------------------------------------------------------
  // Capture after the synchroniser has filled, then hold for good
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_ff <= 2'h0;
      if_mode <= `SRS_MODE_SMB;
      slave_addr <= `SRS_ADDR_VDD;
    end else if (settle_ff != 2'h3) begin
      settle_ff <= settle_ff + 2'h1;
      if (settle_ff == 2'h2) begin
        case (strap_sync)
          `SRS_STRAP_R47K: if_mode <= `SRS_MODE_SPI4;
          `SRS_STRAP_R56K: if_mode <= `SRS_MODE_SPI3;
          `SRS_STRAP_R68K: if_mode <= `SRS_MODE_LINK;
          default: if_mode <= `SRS_MODE_SMB;
        endcase
        case (strap_sync)
          `SRS_STRAP_R82K: slave_addr <= `SRS_ADDR_R82K;
          `SRS_STRAP_R100K: slave_addr <= `SRS_ADDR_R100K;
          `SRS_STRAP_R120K: slave_addr <= `SRS_ADDR_R120K;
          `SRS_STRAP_R150K: slave_addr <= `SRS_ADDR_R150K;
          default: slave_addr <= `SRS_ADDR_VDD;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Power-up quiet time; bus traffic before it is simply ignored
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_ff <= {`SRS_CNT_W{1'b0}};
      ready <= 1'b0;
    end else if (!ready) begin
      quiet_ff <= quiet_ff + 1'b1;
      if (quiet_ff == QUIET_CYC - 1'b1) begin
        ready <= 1'b1;
      end
    end
  end

endmodule // srs_strap

// *** rtl/srs_slave.v ***
// Purpose: Two-wire slave giving a host access to an 8-bit register space
// Assumes: Host drives the bus clock; register file answers in the same cycle
// Notes: Bus pins pass two flops; clock is never stretched by this end
`include "srs_map.vh"

module srs_slave #(
  parameter [`SRS_CNT_W-1:0] LOW_CYC = `SRS_LOW_CYC,
  parameter [`SRS_CNT_W-1:0] IDLE_CYC = `SRS_IDLE_CYC,
  parameter [`SRS_CNT_W-1:0] QUIET_CYC = `SRS_QUIET_CYC
) (
  input wire CLK, // Core clock, 125 MHz
  input wire RST_N, // Async reset, active low
  input wire [2:0] STRAP_LVL, // Interface-select strap level code
  input wire CS_N, // SPI chip select, unused here
  input wire TIMEOUT_EN, // Configuration timeout-enable bit
  input wire SCL_IN, // Bus clock pin level
  input wire SDA_IN, // Bus data pin level
  output wire SDA_OUT, // Bus data drive value
  output wire SDA_OE_N, // Bus data enable, low drives
  output wire [1:0] IF_MODE, // Selected host interface
  output wire [6:0] SLAVE_ADDR, // Strap slave address
  output wire BUSY, // Transfer in progress
  output wire [7:0] REG_ADDR, // Register pointer
  output reg [7:0] REG_WDATA, // Write data
  output reg REG_WR, // Write strobe, one cycle
  input wire [7:0] REG_RDATA // Read data at REG_ADDR
);
  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_ADDR_ACK = 4'h2;
  localparam [3:0] ST_REGA = 4'h3;
  localparam [3:0] ST_REGA_ACK = 4'h4;
  localparam [3:0] ST_WDATA = 4'h5;
  localparam [3:0] ST_WDATA_ACK = 4'h6;
  localparam [3:0] ST_RDATA = 4'h7;
  localparam [3:0] ST_RACK = 4'h8;
  localparam [3:0] ST_IGNORE = 4'h9;

  wire [1:0] pin_sync;
  wire scl_s;
  wire sda_s;
  wire ready;
  wire smb_on;
  reg scl_d_ff;
  reg sda_d_ff;
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [2:0] bit_cnt_ff;
  reg byte_done_ff;
  reg [7:0] shift_ff;
  reg [7:0] tx_ff;
  reg [7:0] ptr_ff;
  reg rd_ff;
  reg ara_ff;
  reg host_ack_ff;
  reg drv_ff;
  reg [`SRS_CNT_W-1:0] low_cnt_ff;
  reg [`SRS_CNT_W-1:0] idle_cnt_ff;
  reg low_to_ff;
  reg idle_to_ff;

  // ---------------------------------------------------------------
  // Pin synchronisers and strap decode
  // ---------------------------------------------------------------
  srs_sync #(.W(2)) u_pins (
    .clk(CLK),
    .rst_n(RST_N),
    .d_in({SCL_IN, SDA_IN}),
    .q_out(pin_sync)
  );
  assign scl_s = pin_sync[1];
  assign sda_s = pin_sync[0];

  srs_strap #(.QUIET_CYC(QUIET_CYC)) u_strap (
    .clk(CLK),
    .rst_n(RST_N),
    .strap_lvl(STRAP_LVL),
    .if_mode(IF_MODE),
    .slave_addr(SLAVE_ADDR),
    .ready(ready)
  );

  // Active only in two-wire mode after quiet time; chip select plays no part
  assign smb_on = ready & (IF_MODE == `SRS_MODE_SMB);

  // ---------------------------------------------------------------
  // Edge and condition detection on synchronised lines
  // ---------------------------------------------------------------
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_det = smb_on & scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_det = smb_on & scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  wire addr_hit = (shift_ff[7:1] == SLAVE_ADDR);
  wire ara_hit = (shift_ff[7:1] == `SRS_ADDR_ARA);

  // ---------------------------------------------------------------
  // Clock-low timeout, only while enabled; idle detector always on
  // ---------------------------------------------------------------
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_cnt_ff <= {`SRS_CNT_W{1'b0}};
      low_to_ff <= 1'b0;
      idle_cnt_ff <= {`SRS_CNT_W{1'b0}};
      idle_to_ff <= 1'b0;
    end else begin
      low_to_ff <= 1'b0;
      idle_to_ff <= 1'b0;
      if (!TIMEOUT_EN || scl_s) begin
        low_cnt_ff <= {`SRS_CNT_W{1'b0}};
      end else if (low_cnt_ff == LOW_CYC - 1'b1) begin
        low_cnt_ff <= {`SRS_CNT_W{1'b0}};
        low_to_ff <= 1'b1;
      end else begin
        low_cnt_ff <= low_cnt_ff + 1'b1;
      end
      // Saturate so a long idle fires the reset once, not repeatedly
      if (!(scl_s && sda_s)) begin
        idle_cnt_ff <= {`SRS_CNT_W{1'b0}};
      end else if (idle_cnt_ff != IDLE_CYC) begin
        idle_cnt_ff <= idle_cnt_ff + 1'b1;
        if (idle_cnt_ff == IDLE_CYC - 1'b1) begin
          idle_to_ff <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Next state on clock falls; conditions and timeouts take priority
  // ---------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    if (!smb_on || stop_det || low_to_ff || idle_to_ff) begin
      nxt_state = ST_IDLE;
    end else if (start_det) begin
      nxt_state = ST_ADDR;
    end else if (scl_fall) begin
      case (state_ff)
        ST_ADDR: begin
          if (byte_done_ff) begin
            nxt_state = (addr_hit || ara_hit) ? ST_ADDR_ACK : ST_IGNORE;
          end
        end
        ST_ADDR_ACK: begin
          nxt_state = rd_ff ? ST_RDATA : ST_REGA;
        end
        ST_REGA: begin
          if (byte_done_ff) begin
            nxt_state = ST_REGA_ACK;
          end
        end
        ST_REGA_ACK: nxt_state = ST_WDATA;
        ST_WDATA: begin
          if (byte_done_ff) begin
            nxt_state = ST_WDATA_ACK;
          end
        end
        ST_WDATA_ACK: nxt_state = ST_WDATA;
        ST_RDATA: begin
          if (bit_cnt_ff == 3'h7) begin
            nxt_state = ST_RACK;
          end
        end
        ST_RACK: nxt_state = host_ack_ff ? ST_RDATA : ST_IGNORE;
        default: nxt_state = state_ff;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Shifting, pointer, register strobes and data-line drive
  // ---------------------------------------------------------------
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 3'h0;
      byte_done_ff <= 1'b0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= `SRS_PTR_RST;
      rd_ff <= 1'b0;
      ara_ff <= 1'b0;
      host_ack_ff <= 1'b0;
      drv_ff <= 1'b0;
      REG_WDATA <= 8'h00;
      REG_WR <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      REG_WR <= 1'b0;
      if (!smb_on || stop_det || low_to_ff || idle_to_ff || start_det) begin
        // Release the line and restart byte framing
        drv_ff <= 1'b0;
        bit_cnt_ff <= 3'h0;
        byte_done_ff <= 1'b0;
      end else if (scl_rise) begin
        case (state_ff)
          ST_ADDR, ST_REGA, ST_WDATA: begin
            shift_ff <= {shift_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            byte_done_ff <= (bit_cnt_ff == 3'h7);
          end
          ST_RACK: begin
            host_ack_ff <= ~sda_s;
            if (!sda_s) begin
              ptr_ff <= ptr_ff + 8'h01;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        byte_done_ff <= 1'b0;
        case (state_ff)
          ST_ADDR: begin
            if (byte_done_ff) begin
              rd_ff <= shift_ff[0];
              ara_ff <= ara_hit & ~addr_hit;
              drv_ff <= addr_hit | ara_hit;
            end
          end
          ST_REGA: begin
            if (byte_done_ff) begin
              ptr_ff <= shift_ff;
              drv_ff <= 1'b1;
            end
          end
          ST_WDATA: begin
            if (byte_done_ff) begin
              REG_WDATA <= shift_ff;
              REG_WR <= 1'b1;
              drv_ff <= 1'b1;
            end
          end
          ST_WDATA_ACK: begin
            drv_ff <= 1'b0;
            ptr_ff <= ptr_ff + 8'h01;
          end
          ST_REGA_ACK: begin
            drv_ff <= 1'b0;
          end
          ST_ADDR_ACK, ST_RACK: begin
            // Load the next byte and present its MSB; alert reply is our address
            if ((state_ff == ST_ADDR_ACK && rd_ff) || (state_ff == ST_RACK && host_ack_ff)) begin
              tx_ff <= ara_ff ? {SLAVE_ADDR, 1'b0} : REG_RDATA;
              drv_ff <= ara_ff ? ~SLAVE_ADDR[6] : ~REG_RDATA[7];
              bit_cnt_ff <= 3'h0;
            end else begin
              drv_ff <= 1'b0;
            end
          end
          ST_RDATA: begin
            if (bit_cnt_ff == 3'h7) begin
              drv_ff <= 1'b0; // Host owns the acknowledge bit
            end else begin
              tx_ff <= {tx_ff[6:0], 1'b0};
              drv_ff <= ~tx_ff[6];
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
          end
          default: drv_ff <= 1'b0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs: data is only ever pulled low; the clock pin has no driver
  // ---------------------------------------------------------------
  assign SDA_OUT = 1'b0;
  assign SDA_OE_N = ~drv_ff;
  assign REG_ADDR = ptr_ff;
  assign BUSY = (state_ff != ST_IDLE) && (state_ff != ST_IGNORE);

endmodule // srs_slave

// *** sim/srs_slave_sva.sv ***
// Purpose: Port-level protocol checks on the two-wire register access slave
// Assumes: Counts are shortened by the same parameters as the design
// Notes: Margins of a few cycles cover the pin synchroniser latency
module srs_slave_sva #(
  parameter int LOW_CYC = 200, // Clock-low timeout cycles
  parameter int IDLE_CYC = 100 // Bus idle cycles
) (
  input wire logic CLK, // Core clock
  input wire logic RST_N, // Async reset, active low
  input wire logic TIMEOUT_EN, // Timeout enable
  input wire logic SCL_IN, // Bus clock level
  input wire logic SDA_IN, // Bus data level
  input wire logic SDA_OE_N, // Data enable, low drives
  input wire logic [1:0] IF_MODE, // Selected interface
  input wire logic BUSY, // Transfer in progress
  input wire logic [7:0] REG_ADDR, // Register pointer
  input wire logic REG_WR // Write strobe
);
  timeunit 1ns;
  timeprecision 10ps;
  logic [21:0] lo_cnt_ff;
  logic [21:0] to_cnt_ff;
  logic [21:0] hi_cnt_ff;
  logic [7:0] step_ff;
  // ---------------------------------------------------------------
  // Run lengths and expected pointer after a write
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      lo_cnt_ff <= 22'h0;
      to_cnt_ff <= 22'h0;
      hi_cnt_ff <= 22'h0;
      step_ff <= 8'h00;
    end else begin
      lo_cnt_ff <= SCL_IN ? 22'h0 : lo_cnt_ff + 22'h1;
      to_cnt_ff <= (SCL_IN || !TIMEOUT_EN) ? 22'h0 : to_cnt_ff + 22'h1;
      hi_cnt_ff <= (SCL_IN && SDA_IN) ? hi_cnt_ff + 22'h1 : 22'h0;
      if (REG_WR) step_ff <= REG_ADDR + 8'h01; // Wraps FF to 00 by width
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_wr_one_cycle: assert property (REG_WR |=> !REG_WR)
    else $error("write strobe longer than one cycle");
  a_ptr_step: assert property (REG_WR |=> ##[1:40] (REG_ADDR == step_ff))
    else $error("pointer did not step after write");
  a_wr_clk_low: assert property (REG_WR |-> !SCL_IN)
    else $error("write strobe outside clock low");
  a_oe_clk_low: assert property ($changed(SDA_OE_N) |-> !SCL_IN)
    else $error("data drive changed while clock high");
  a_mode_quiet: assert property (IF_MODE != 2'h3 |-> SDA_OE_N)
    else $error("data driven outside two-wire mode");
  a_start_busy: assert property ($fell(SDA_IN) && SCL_IN && IF_MODE == 2'h3 |-> ##[1:6] BUSY)
    else $error("start not taken");
  a_stop_idle: assert property ($rose(SDA_IN) && SCL_IN |-> ##[1:6] !BUSY)
    else $error("stop did not end transfer");
  a_idle_reset: assert property (hi_cnt_ff > IDLE_CYC + 6 |-> !BUSY)
    else $error("idle bus did not reset slave");
  a_low_reset: assert property (to_cnt_ff > LOW_CYC + 6 |-> !BUSY)
    else $error("clock-low timeout did not reset slave");
  a_no_early_reset: assert property (!TIMEOUT_EN && lo_cnt_ff > 12 && BUSY |=> BUSY)
    else $error("slave reset while timeout disabled");
endmodule // srs_slave_sva

bind srs_slave srs_slave_sva #(.LOW_CYC(LOW_CYC), .IDLE_CYC(IDLE_CYC)) u_sva (
  .CLK(CLK), .RST_N(RST_N), .TIMEOUT_EN(TIMEOUT_EN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OE_N(SDA_OE_N), .IF_MODE(IF_MODE), .BUSY(BUSY), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR));

// *** sim/srs_host.sv ***
// Purpose: Host controller model driving the two-wire bus
// Assumes: Data line has a pull-up; the bench resolves the wired level
// Notes: 125 ns bit, data moves a quarter bit after the clock falls
module srs_host (
  output logic scl, // Bus clock, host only
  output logic sda_o, // Host data drive, 1 releases
  input wire logic sda // Resolved data line
);
  timeunit 1ns;
  timeprecision 10ps;
  localparam realtime Q = 31.25;
  // Idle bus at time zero
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  // ---------------------------------------------------------------
  // Bus conditions
  // ---------------------------------------------------------------
  // Extra quarter lets the slave drop its acknowledge first
  task automatic start();
    sda_o = 1'b1;
    #(2 * Q) scl = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_o = 1'b0;
    #Q scl = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask
  // Leaves both lines high with no stop
  task automatic release_bus();
    sda_o = 1'b1;
    #Q scl = 1'b1;
    #Q;
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_o = b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Byte out, MSB first, returns the slave acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  // Byte in; the last one is not acknowledged
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
endmodule // srs_host

// *** sim/test_smbus_register_access_slave.sv ***
// Purpose: Self-checking bench for the two-wire register access slave
// Assumes: Shortened counts: low 200, idle 100, quiet 50 cycles
// Notes: The bench holds the register file the slave reaches
`include "srs_map.vh"
module test_smbus_register_access_slave;
  timeunit 1ns;
  timeprecision 10ps;
  localparam logic [6:0] SA = `SRS_ADDR_VDD;
  logic clk, rst_n, cs_n, tmo_en, host_sda;
  logic [2:0] strap;
  wire scl, sda_out, sda_oe_n, busy, reg_wr;
  wire [1:0] if_mode;
  wire [6:0] slave_addr;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire sda = host_sda & (sda_oe_n | sda_out); // Wired level with pull-up
  logic [7:0] regs [256];
  logic [7:0] d;
  int num_errors = 0;
  int compares = 0;
  assign reg_rdata = regs[reg_addr];
  srs_slave #(.LOW_CYC(22'd200), .IDLE_CYC(22'd100), .QUIET_CYC(22'd50)) DUT (
    .CLK(clk), .RST_N(rst_n), .STRAP_LVL(strap), .CS_N(cs_n), .TIMEOUT_EN(tmo_en),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .IF_MODE(if_mode),
    .SLAVE_ADDR(slave_addr), .BUSY(busy), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RDATA(reg_rdata));
  srs_host u_host (.scl(scl), .sda_o(host_sda), .sda(sda));
  // Register file store, cleared while reset is held; the only writer of regs
  always @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) regs[i] <= 8'h00;
    end else if (reg_wr === 1'b1) begin
      regs[reg_addr] <= reg_wdata;
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] b, input logic exp_ack);
    logic a;
    u_host.wbyte(b, a);
    chk("ack", {7'h00, exp_ack}, {7'h00, a});
  endtask
  task automatic rd(input logic last, input logic [7:0] exp);
    u_host.rbyte(last, d);
    chk("read data", exp, d);
  endtask
  // Host keeps off the bus until the quiet time is over
  task automatic do_reset(input logic [2:0] code, input logic cs);
    @(posedge clk);
    #1 rst_n = 1'b0;
    strap = code;
    cs_n = cs;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (60) @(posedge clk);
  endtask
  task automatic summarize();
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Block write across the FF to 00 wrap
  task automatic t_write();
    u_host.start();
    wr({SA, 1'b0}, 1'b1);
    wr(8'hFE, 1'b1);
    wr(8'h11, 1'b1);
    wr(8'h22, 1'b1);
    wr(8'h33, 1'b1);
    u_host.stop();
    chk("reg FE", 8'h11, regs[8'hFE]);
    chk("reg FF", 8'h22, regs[8'hFF]);
    chk("reg 00", 8'h33, regs[8'h00]);
  endtask
  // Block read with repeated start and a stretched clock
  task automatic t_read();
    u_host.start();
    wr({SA, 1'b0}, 1'b1);
    wr(8'hFE, 1'b1);
    u_host.start();
    wr({SA, 1'b1}, 1'b1);
    rd(1'b0, 8'h11);
    #400;
    rd(1'b0, 8'h22);
    rd(1'b1, 8'h33);
    u_host.stop();
  endtask
  // Write byte, then send byte moves the pointer back; receive byte twice
  task automatic t_send_recv();
    u_host.start();
    wr({SA, 1'b0}, 1'b1);
    wr(8'h05, 1'b1);
    wr(8'hA5, 1'b1);
    u_host.stop();
    chk("pointer", 8'h06, reg_addr);
    u_host.start();
    wr({SA, 1'b0}, 1'b1);
    wr(8'h05, 1'b1);
    u_host.stop();
    chk("pointer", 8'h05, reg_addr);
    repeat (2) begin
      u_host.start();
      wr({SA, 1'b1}, 1'b1);
      rd(1'b1, 8'hA5);
      u_host.stop();
    end
  endtask
  // Neighbouring address is refused, alert response address is answered
  task automatic t_foreign();
    u_host.start();
    wr({SA ^ 7'h01, 1'b1}, 1'b0);
    rd(1'b1, 8'hFF);
    u_host.stop();
    u_host.start();
    wr({`SRS_ADDR_ARA, 1'b1}, 1'b1);
    rd(1'b1, {SA, 1'b0});
    u_host.stop();
  endtask
  // Clock-low timeout off, then on, then bus idle
  task automatic t_timeouts();
    u_host.start();
    wr({SA, 1'b0}, 1'b1);
    repeat (300) @(posedge clk);
    chk("busy held", 8'h01, {7'h00, busy});
    u_host.stop();
    @(posedge clk);
    #1 tmo_en = 1'b1;
    u_host.start();
    wr({SA, 1'b0}, 1'b1);
    repeat (250) @(posedge clk);
    chk("busy after low", 8'h00, {7'h00, busy});
    u_host.stop();
    @(posedge clk);
    #1 tmo_en = 1'b0;
    u_host.start();
    wr({SA, 1'b0}, 1'b1);
    u_host.release_bus();
    repeat (150) @(posedge clk);
    chk("busy after idle", 8'h00, {7'h00, busy});
  endtask
  // Every strap code, chip select at both levels
  task automatic t_strap();
    logic [6:0] ea;
    for (int k = 0; k < 8; k++) begin
      ea = (k == 3) ? 7'h2C : (k == 4) ? 7'h2B : (k == 5) ? 7'h2A : (k == 6) ? 7'h29 : 7'h28;
      do_reset(k[2:0], k[0]);
      chk("mode", (k < 3) ? k[7:0] : 8'h03, {6'h00, if_mode});
      if (k > 2) chk("slave addr", {1'b0, ea}, {1'b0, slave_addr});
      u_host.start();
      wr({ea, 1'b0}, k > 2);
      u_host.stop();
    end
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    strap = 3'h7;
    cs_n = 1'b0;
    tmo_en = 1'b0;
    do_reset(3'h7, 1'b0);
    t_write();
    t_read();
    t_send_recv();
    t_foreign();
    t_timeouts();
    t_strap();
    summarize();
  end
  // Watchdog, well past the expected run of some 60 us
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
endmodule // test_smbus_register_access_slave
